// [verilog/vmt_pkg.sv]
// Purpose: Shared constants and types of the master transmit path.
// Assumes: APB at 20 MHz, byte offsets, one 32-bit word per register.
// Notes: Entry layout is control, address, data (72 bits).
`default_nettype none
package vmt_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] A_CSR = 8'h00;
  localparam logic [7:0] A_CTL = 8'h04;
  localparam logic [7:0] A_ADDR = 8'h08;
  localparam logic [7:0] A_DATA = 8'h0c;
  localparam logic [7:0] A_UPPER = 8'h10;
  localparam logic [7:0] A_BLEN = 8'h14;
  // Control/status bits
  localparam int CSR_CPL = 0;
  localparam int CSR_VERR = 1;
  localparam int CSR_QRST = 2;
  localparam int CSR_FILL = 3;
  localparam int CSR_MBLT = 4;
  localparam int CSR_SPACE = 5;
  localparam int CSR_MODE_ERR = 7;
  localparam int CSR_CNT = 8;
  localparam int CNT_W = 4;
  // ==========================================================
  // Entry control field
  localparam int CTL_MBLT = 7;
  localparam int CTL_BLT = 6;
  localparam int CTL_SPACE = 2;
  localparam logic [1:0] SP_A16 = 2'h0;
  localparam logic [1:0] SP_A24 = 2'h1;
  localparam logic [1:0] SP_A32 = 2'h2;
  localparam logic [1:0] SP_A64 = 2'h3;
  // ==========================================================
  // Queue and timing
  localparam int unsigned VMT_DEPTH = 15;
  localparam int unsigned MBLT_SLOTS = 1;
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned LB_TMO_NS = 16000;
  localparam int unsigned LB_TMO_CYC = LB_TMO_NS / CLK_NS;
  localparam int unsigned BURST_MIN_LW = 4;
  localparam logic [31:0] LW_BYTES = 32'h4;
  localparam logic [31:0] DLW_BYTES = 32'h8;
  // ==========================================================
  // Types
  typedef struct packed {
    logic [7:0] ctl;
    logic [31:0] addr;
    logic [31:0] data;
  } vmt_entry_t;
  typedef struct packed {
    logic req;
    logic write;
    logic iack;
    logic dma;
    vmt_entry_t ent;
  } vmt_lreq_t;
  typedef struct packed {
    logic dtack_n;
    logic berr_n;
    logic grant;
  } vmt_vme_in_t;
  localparam vmt_vme_in_t VME_IDLE = '{1'b1, 1'b1, 1'b0};
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_ARB = 2'b01,
    S_XFER = 2'b10,
    S_REL = 2'b11
  } vmt_state_t;
endpackage
`default_nettype wire

// [verilog/vmt_master_tx_path.sv]
// Purpose: Master transmit path, local bus to VMEbus, with APB registers.
// Assumes: Local request logic shares clk_sys; VMEbus pins are async.
// Notes: Queued and coupled cycles share one VMEbus engine.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Reads always run coupled, never queued
// - Coupled bit selects coupled writes, default decoupled
// - Drain queue before coupled mode takes effect
// - Coupled cycle waits, passes termination back
// - Coupled bus error sets flag, interrupts
// - Drain transmit queue before coupled cycles, receive queue before coupled writes
// - Decoupled write queued, both size acks
// - Request bus when non-empty; fill option
// - Reads and IACK wait for empty queue
// - Full queue stalls writes, then timeout error
// - 72-bit entries, three capture registers
// - Eight control bits qualify each entry
// - Address and data captures, 32 bits
// - Queued bus error releases bus, flags
// - Error: keep queuing, never dequeue
// - Captures hold failed entry; clear discards
// - DMA block transfers always decoupled
// - MBLT allowed only with A64/A32; only DMA entries are refused, the CSR only flags a mode error
// - A64 upper address from register
// - Burst alignment and boundary restarts
// - DMA burst ends on four causes
// - Release local bus at 15/14 entries
// - Reset bit empties the queue
module vmt_master_tx_path import vmt_pkg::*; #(
  parameter int unsigned DEPTH = VMT_DEPTH,
  parameter int unsigned TMO_CYC = LB_TMO_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire vmt_lreq_t lb_in,
  input wire logic rxq_empty,
  input wire logic dma_active,
  input wire logic dma_count_done,
  input wire logic dma_hp_grant,
  output logic local_size_ack_hi,
  output logic local_size_ack_lo,
  output logic local_bus_error,
  output logic [31:0] lb_rdata,
  output logic local_interrupt_out,
  output logic lb_release,
  output logic burst_end,
  output logic burst_restart,
  output logic align_error,
  input wire vmt_vme_in_t vme_in,
  input wire logic [31:0] vme_rdata,
  output logic vme_bus_req,
  output logic vme_strobe,
  output logic vme_write,
  output vmt_entry_t vme_entry,
  output logic [31:0] vme_upper_addr
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(DEPTH);
  localparam int TW = $clog2(TMO_CYC + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [CW-1:0] MBLT_THR = CW'(DEPTH - MBLT_SLOTS);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
  localparam logic [TW-1:0] TMO_LAST = TW'(TMO_CYC - 1);

  // ==========================================================
  // Pin synchronisers
  vmt_vme_in_t vme_m_ff, vme_s_ff;
  logic [31:0] rd_m_ff, rd_s_ff;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      vme_m_ff <= VME_IDLE;
      vme_s_ff <= VME_IDLE;
      rd_m_ff <= 32'h0;
      rd_s_ff <= 32'h0;
    end else begin
      vme_m_ff <= vme_in;
      vme_s_ff <= vme_m_ff;
      rd_m_ff <= vme_rdata;
      rd_s_ff <= rd_m_ff;
    end
  end

  // ==========================================================
  // State
  vmt_entry_t mem_ff [DEPTH];
  vmt_entry_t nxt_mem [DEPTH];
  vmt_entry_t cur_ff, nxt_cur, cap_ff, nxt_cap;
  vmt_state_t state_ff, nxt_state;
  logic [PW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [CW-1:0] cnt_ff, nxt_cnt, rel_thr;
  logic [TW-1:0] tmo_ff, nxt_tmo;
  logic [5:0] beats_ff, nxt_beats;
  logic [1:0] blen_ff, nxt_blen, space_ff, nxt_space;
  logic [31:0] upper_ff, nxt_upper, rdata_ff, nxt_rdata;
  logic [31:0] vupper_ff, nxt_vupper, bmask;
  logic cpl_mode_ff, nxt_cpl_mode, err_ff, nxt_err;
  logic fill_ff, nxt_fill, mblt_ff, nxt_mblt;
  logic cpl_ff, nxt_cpl, cwr_ff, nxt_cwr;
  logic breq_ff, nxt_breq, stb_ff, nxt_stb;
  logic drain_ff, nxt_drain, ack_ff, nxt_ack;
  logic lberr_ff, nxt_lberr, rel_ff, nxt_rel;
  logic bend_ff, nxt_bend, brst_ff, nxt_brst;
  logic alerr_ff, nxt_alerr;
  logic wr_en, csr_wr, qrst, err_clr, err_set;
  logic live, qpath, full, push, pop, cstart, gate, mode_err;
  logic bad_dma, dpush;
  logic [31:0] step;
  logic [5:0] bmax;
  logic apb_rdy_ff, nxt_apb_rdy, slv_ff, nxt_slv;
  logic [31:0] prd_ff, nxt_prd;

  // ==========================================================
  // APB slave: answers in the first access cycle
  always_comb begin
    nxt_apb_rdy = psel & ~penable;
    nxt_slv = 1'b0;
    nxt_prd = 32'h0;
    if (psel && !penable) begin
      unique case (paddr)
        A_CSR: begin
          nxt_prd[CSR_CPL] = cpl_mode_ff;
          nxt_prd[CSR_VERR] = err_ff;
          nxt_prd[CSR_FILL] = fill_ff;
          nxt_prd[CSR_MBLT] = mblt_ff;
          nxt_prd[CSR_SPACE +: 2] = space_ff;
          nxt_prd[CSR_MODE_ERR] = mode_err;
          nxt_prd[CSR_CNT +: CNT_W] = CNT_W'(cnt_ff);
        end
        A_CTL: nxt_prd[7:0] = cap_ff.ctl;
        A_ADDR: nxt_prd = cap_ff.addr;
        A_DATA: nxt_prd = cap_ff.data;
        A_UPPER: nxt_prd = upper_ff;
        A_BLEN: nxt_prd[1:0] = blen_ff;
        default: nxt_slv = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      apb_rdy_ff <= 1'b0;
      slv_ff <= 1'b0;
      prd_ff <= 32'h0;
    end else begin
      apb_rdy_ff <= nxt_apb_rdy;
      slv_ff <= nxt_slv;
      prd_ff <= nxt_prd;
    end
  end

  // ==========================================================
  // Core: queue, local side, VMEbus engine, DMA status
  always_comb begin
    nxt_mem = mem_ff;
    nxt_cur = cur_ff;
    nxt_cap = cap_ff;
    nxt_state = state_ff;
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    nxt_tmo = tmo_ff;
    nxt_beats = beats_ff;
    nxt_blen = blen_ff;
    nxt_space = space_ff;
    nxt_upper = upper_ff;
    nxt_rdata = rdata_ff;
    nxt_vupper = vupper_ff;
    nxt_cpl_mode = cpl_mode_ff;
    nxt_fill = fill_ff;
    nxt_mblt = mblt_ff;
    nxt_cpl = cpl_ff;
    nxt_cwr = cwr_ff;
    nxt_breq = breq_ff;
    nxt_stb = stb_ff;
    nxt_drain = drain_ff;
    nxt_ack = 1'b0;
    nxt_lberr = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    cstart = 1'b0;
    err_set = 1'b0;
    // Register writes take effect at the access edge
    wr_en = psel & penable & apb_rdy_ff & pwrite & ~slv_ff;
    csr_wr = wr_en && (paddr == A_CSR);
    qrst = csr_wr & pwdata[CSR_QRST];
    err_clr = csr_wr & pwdata[CSR_VERR];
    if (csr_wr) begin
      nxt_cpl_mode = pwdata[CSR_CPL];
      nxt_fill = pwdata[CSR_FILL];
      nxt_mblt = pwdata[CSR_MBLT];
      nxt_space = pwdata[CSR_SPACE +: 2];
    end
    if (wr_en && paddr == A_UPPER) begin
      nxt_upper = pwdata;
    end
    if (wr_en && paddr == A_BLEN) begin
      nxt_blen = pwdata[1:0];
    end
    // MBLT only in A64 or A32
    mode_err = mblt_ff & (space_ff == SP_A24 || space_ff == SP_A16);
    full = (cnt_ff == FULL_CNT);
    // Registered acks are seen one edge late; mask the echo cycle
    live = lb_in.req & ~ack_ff & ~lberr_ff & ~cpl_ff;
    // DMA and decoupled writes go to the queue
    qpath = lb_in.write & ~lb_in.iack & (lb_in.dma | ~cpl_mode_ff);
    bad_dma = lb_in.dma & lb_in.ent.ctl[CTL_MBLT] & ~lb_in.ent.ctl[3];
    if (live) begin
      nxt_tmo = tmo_ff + 1'b1;
      if (qpath && bad_dma) begin
        nxt_lberr = 1'b1;
        nxt_tmo = '0;
      end else if (qpath && !full) begin
        push = 1'b1;
        nxt_ack = 1'b1;
        nxt_tmo = '0;
      end else if (!qpath && state_ff == S_IDLE && cnt_ff == '0 &&
                   (rxq_empty || !lb_in.write)) begin
        cstart = 1'b1;
        nxt_tmo = '0;
      end else if (tmo_ff == TMO_LAST) begin
        nxt_lberr = 1'b1;
        nxt_tmo = '0;
      end
    end else begin
      nxt_tmo = '0;
    end
    // fill option holds requests until full, then drains
    gate = ~(dma_active & fill_ff) | full | drain_ff;
    if (full) begin
      nxt_drain = 1'b1;
    end else if (cnt_ff == '0) begin
      nxt_drain = 1'b0;
    end
    unique case (state_ff)
      S_IDLE: begin
        if (cstart) begin
          nxt_cur = lb_in.ent;
          nxt_cwr = lb_in.write & ~lb_in.iack;
          nxt_cpl = 1'b1;
          nxt_breq = 1'b1;
          nxt_state = S_ARB;
        end else if (cnt_ff != '0 && !err_ff && gate) begin
          // oldest entry first, none while in error
          nxt_cur = mem_ff[rd_ff];
          nxt_cwr = 1'b1;
          nxt_cpl = 1'b0;
          nxt_breq = 1'b1;
          nxt_state = S_ARB;
        end
        nxt_vupper = (nxt_cur.ctl[CTL_SPACE +: 2] == SP_A64) ?
                     upper_ff : 32'h0;
      end
      S_ARB: begin
        if (vme_s_ff.grant) begin
          nxt_stb = 1'b1;
          nxt_state = S_XFER;
        end
      end
      S_XFER: begin
        if (!vme_s_ff.berr_n) begin
          err_set = 1'b1;
          nxt_stb = 1'b0;
          nxt_breq = 1'b0;
          nxt_state = S_REL;
          if (cpl_ff) begin
            // bus error passed to local master
            nxt_lberr = 1'b1;
          end else begin
            nxt_cap = cur_ff;
          end
        end else if (!vme_s_ff.dtack_n) begin
          nxt_stb = 1'b0;
          nxt_breq = 1'b0;
          nxt_state = S_REL;
          if (cpl_ff) begin
            nxt_ack = 1'b1;
            nxt_rdata = rd_s_ff;
          end else begin
            pop = cnt_ff != '0;
            nxt_cap = cur_ff;
          end
        end
      end
      S_REL: begin
        if (vme_s_ff.dtack_n && vme_s_ff.berr_n) begin
          nxt_cpl = 1'b0;
          nxt_state = S_IDLE;
        end
      end
    endcase
    nxt_err = err_set | (err_ff & ~err_clr);
    if (err_clr && err_ff && !err_set && cnt_ff != '0) begin
      pop = 1'b1;
    end
    if (qrst) begin
      nxt_wr = '0;
      nxt_rd = '0;
      nxt_cnt = '0;
    end else begin
      nxt_cnt = cnt_ff - CW'(pop);
      if (pop) begin
        nxt_rd = (rd_ff == LAST_PTR) ? '0 : rd_ff + 1'b1;
      end
    end
    if (push) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (nxt_wr == PW'(i)) begin
          nxt_mem[i] = lb_in.ent;
        end
      end
      nxt_cnt = nxt_cnt + 1'b1;
      nxt_wr = (nxt_wr == LAST_PTR) ? '0 : nxt_wr + 1'b1;
    end
    // release threshold, one slot less for MBLT
    rel_thr = mblt_ff ? MBLT_THR : FULL_CNT;
    nxt_rel = dma_active & (nxt_cnt >= rel_thr);
    dpush = push & lb_in.dma;
    step = lb_in.ent.ctl[CTL_MBLT] ? DLW_BYTES : LW_BYTES;
    bmask = (LW_BYTES << (BURST_MIN_LW'(0) + blen_ff + 2'd2)) - 32'h1;
    bmax = 6'(BURST_MIN_LW) << blen_ff;
    nxt_brst = dpush & (((lb_in.ent.addr + step) & bmask) == 32'h0);
    nxt_alerr = dpush & (beats_ff == '0) &
                ((lb_in.ent.addr & (step - 32'h1)) != 32'h0);
    nxt_bend = dma_active & ((dpush & (beats_ff + 1'b1 == bmax)) |
               dma_count_done | dma_hp_grant | (nxt_cnt == FULL_CNT));
    if (nxt_bend || nxt_brst) begin
      nxt_beats = '0;
    end else if (dpush) begin
      nxt_beats = beats_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
      cur_ff <= '0;
      cap_ff <= '0;
      state_ff <= S_IDLE;
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      tmo_ff <= '0;
      beats_ff <= '0;
      blen_ff <= 2'h0;
      space_ff <= SP_A32;
      upper_ff <= 32'h0;
      rdata_ff <= 32'h0;
      vupper_ff <= 32'h0;
      cpl_mode_ff <= 1'b0;
      err_ff <= 1'b0;
      fill_ff <= 1'b0;
      mblt_ff <= 1'b0;
      cpl_ff <= 1'b0;
      cwr_ff <= 1'b0;
      breq_ff <= 1'b0;
      stb_ff <= 1'b0;
      drain_ff <= 1'b0;
      ack_ff <= 1'b0;
      lberr_ff <= 1'b0;
      rel_ff <= 1'b0;
      bend_ff <= 1'b0;
      brst_ff <= 1'b0;
      alerr_ff <= 1'b0;
    end else begin
      mem_ff <= nxt_mem;
      cur_ff <= nxt_cur;
      cap_ff <= nxt_cap;
      state_ff <= nxt_state;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
      tmo_ff <= nxt_tmo;
      beats_ff <= nxt_beats;
      blen_ff <= nxt_blen;
      space_ff <= nxt_space;
      upper_ff <= nxt_upper;
      rdata_ff <= nxt_rdata;
      vupper_ff <= nxt_vupper;
      cpl_mode_ff <= nxt_cpl_mode;
      err_ff <= nxt_err;
      fill_ff <= nxt_fill;
      mblt_ff <= nxt_mblt;
      cpl_ff <= nxt_cpl;
      cwr_ff <= nxt_cwr;
      breq_ff <= nxt_breq;
      stb_ff <= nxt_stb;
      drain_ff <= nxt_drain;
      ack_ff <= nxt_ack;
      lberr_ff <= nxt_lberr;
      rel_ff <= nxt_rel;
      bend_ff <= nxt_bend;
      brst_ff <= nxt_brst;
      alerr_ff <= nxt_alerr;
    end
  end

  assign prdata = prd_ff;
  assign pready = apb_rdy_ff;
  assign pslverr = slv_ff;
  assign local_size_ack_hi = ack_ff;
  assign local_size_ack_lo = ack_ff;
  assign local_bus_error = lberr_ff;
  assign lb_rdata = rdata_ff;
  assign local_interrupt_out = err_ff;
  assign lb_release = rel_ff;
  assign burst_end = bend_ff;
  assign burst_restart = brst_ff;
  assign align_error = alerr_ff;
  assign vme_bus_req = breq_ff;
  assign vme_strobe = stb_ff;
  assign vme_write = cwr_ff;
  assign vme_entry = cur_ff;
  assign vme_upper_addr = vupper_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_qberr;
    state_ff == S_XFER && !cpl_ff && !vme_s_ff.berr_n;
  endsequence
  sequence s_cberr;
    state_ff == S_XFER && cpl_ff && !vme_s_ff.berr_n;
  endsequence

  a_coupled_drained: assert property (
    state_ff == S_ARB && cpl_ff |-> cnt_ff == '0)
    else $error("coupled cycle with queued entries");
  a_queue_ack: assert property (
    push |=> local_size_ack_hi && local_size_ack_lo ##1 !local_size_ack_hi)
    else $error("queued write not acknowledged once");
  a_queued_berr: assert property (
    s_qberr |=> err_ff && local_interrupt_out && !vme_bus_req &&
                state_ff == S_REL)
    else $error("queued bus error not handled");
  a_coupled_berr: assert property (
    s_cberr |=> local_bus_error && local_interrupt_out ##1 !local_bus_error)
    else $error("coupled bus error not passed back");
  a_error_no_dequeue: assert property (
    err_ff && state_ff == S_IDLE |=> !(state_ff == S_ARB && !cpl_ff))
    else $error("dequeue while error flag set");
  a_full_refuses: assert property (
    full && live && qpath && !bad_dma |=> !local_size_ack_hi)
    else $error("write accepted into full queue");
  a_timeout_error: assert property (
    live && tmo_ff == TMO_LAST && !push && !cstart |=> local_bus_error)
    else $error("stalled cycle did not time out");
  a_queue_reset: assert property (
    qrst |=> cnt_ff <= 1)
    else $error("queue reset left entries");
  a_release_thr: assert property (
    dma_active |=> lb_release == (cnt_ff >= $past(rel_thr)))
    else $error("local bus release threshold wrong");
endmodule
`default_nettype wire

// [tb/vmt_vme_slave.sv]
// Purpose: Behavioural VMEbus slave facing the master transmit path.
// Assumes: Grant follows the request one cycle later unless stalled.
// Notes: Terminates three cycles into a strobe; logs data low bytes.
`timescale 1ns/1ps
`default_nettype none
module vmt_vme_slave import vmt_pkg::*; #(
  parameter logic [31:0] RD_VAL = 32'h5a5a_0001
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic stall,
  input wire logic berr_on,
  input wire logic vme_bus_req,
  input wire logic vme_strobe,
  input wire logic vme_write,
  input wire vmt_entry_t vme_entry,
  output var vmt_vme_in_t vme_in,
  output logic [31:0] vme_rdata,
  output logic [31:0] hist_ff,
  output logic [7:0] seen_ff
);
  logic [2:0] wait_ff;
  logic term;
  assign term = !vme_in.dtack_n || !vme_in.berr_n;
  // ==========================================================
  // Arbitration and termination
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      vme_in <= VME_IDLE;
      wait_ff <= 3'h0;
      hist_ff <= 32'h0;
      seen_ff <= 8'h00;
    end else begin
      vme_in.grant <= vme_bus_req && !stall;
      if (!vme_strobe) begin
        vme_in.dtack_n <= 1'b1;
        vme_in.berr_n <= 1'b1;
        wait_ff <= 3'h0;
      end else if (!term && wait_ff == 3'h2) begin
        if (berr_on) begin
          vme_in.berr_n <= 1'b0;
        end else begin
          vme_in.dtack_n <= 1'b0;
          hist_ff <= {hist_ff[23:0], vme_write ? vme_entry.data[7:0] : 8'hee};
          seen_ff <= seen_ff + 8'h01;
        end
      end else if (!term) begin
        wait_ff <= wait_ff + 3'h1;
      end
    end
  end
  // Inverted pattern when not answering, so stale data never matches
  assign vme_rdata = vme_in.dtack_n ? ~RD_VAL : RD_VAL;
endmodule
`default_nettype wire

// [tb/test_vme_master_tx_path.sv]
// Purpose: Self-checking bench of the master transmit path.
// Assumes: Short local timeout; slave model answers after 3 cycles.
// Notes: All inputs change by NBA right at rising edges.
`timescale 1ns/1ps
`default_nettype none
module test_vme_master_tx_path import vmt_pkg::*;;
  localparam logic [31:0] RD_VAL = 32'h5a5a_0001;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, lb_rdata, vme_rdata, vme_upper_addr, hist, rd;
  logic pready, pslverr, ok, err;
  vmt_lreq_t lb_in = '0;
  logic rxq_empty = 1'b1, dma_active = 1'b0, dma_count_done = 1'b0;
  logic dma_hp_grant = 1'b0, stall = 1'b1, berr_on = 1'b0;
  logic local_size_ack_hi, local_size_ack_lo, local_bus_error;
  logic local_interrupt_out, lb_release, burst_end, burst_restart;
  logic align_error, vme_bus_req, vme_strobe, vme_write;
  vmt_vme_in_t vme_in;
  vmt_entry_t vme_entry;
  logic [7:0] seen;
  logic [7:0] ent_ctl = 8'h08;
  logic [2:0] flags;
  int err_count = 0;
  int checked = 0;
  int i;

  vmt_master_tx_path #(.DEPTH(15), .TMO_CYC(200)) i_dut (.clk_sys(clk_sys),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lb_in(lb_in), .rxq_empty(rxq_empty),
    .dma_active(dma_active), .dma_count_done(dma_count_done),
    .dma_hp_grant(dma_hp_grant), .local_size_ack_hi(local_size_ack_hi),
    .local_size_ack_lo(local_size_ack_lo), .local_bus_error(local_bus_error),
    .lb_rdata(lb_rdata), .local_interrupt_out(local_interrupt_out),
    .lb_release(lb_release), .burst_end(burst_end),
    .burst_restart(burst_restart), .align_error(align_error),
    .vme_in(vme_in), .vme_rdata(vme_rdata), .vme_bus_req(vme_bus_req),
    .vme_strobe(vme_strobe), .vme_write(vme_write), .vme_entry(vme_entry),
    .vme_upper_addr(vme_upper_addr));

  vmt_vme_slave #(.RD_VAL(RD_VAL)) i_slave (.clk_sys(clk_sys),
    .reset(reset), .stall(stall), .berr_on(berr_on),
    .vme_bus_req(vme_bus_req), .vme_strobe(vme_strobe),
    .vme_write(vme_write), .vme_entry(vme_entry), .vme_in(vme_in),
    .vme_rdata(vme_rdata), .hist_ff(hist), .seen_ff(seen));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Access tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask

  // Request held until ack or error, dropped one edge later
  task automatic lb_op(input logic w, input logic [31:0] d,
                       output logic o, output logic [31:0] r);
    lb_in <= '{1'b1, w, 1'b0, dma_active,
               '{ent_ctl, {24'h001000, d[7:0]}, d}};
    do begin
      @(posedge clk_sys);
    end while (local_size_ack_hi !== 1'b1 && local_bus_error !== 1'b1);
    o = local_size_ack_hi === 1'b1 && local_size_ack_lo === 1'b1;
    r = lb_rdata;
    // Burst pulses land with the acknowledge of the same push
    flags = {align_error, burst_end, burst_restart};
    lb_in.req <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic fill_n(input int n);
    int k;
    logic o;
    logic [31:0] r;
    for (k = 0; k < n; k++) begin
      lb_op(1'b1, 32'(k), o, r);
      chk(32'(o), 32'h1);
    end
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rdchk(A_CSR, 32'h40);
    apb(1'b0, 8'h3c, 32'h0, rd, err);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    wr(A_CTL, 32'hff);
    rdchk(A_CTL, 32'h0);
    wr(A_UPPER, 32'hab12_cd34);
    rdchk(A_UPPER, 32'hab12_cd34);
    // Queued writes while the slave withholds grant
    for (i = 1; i < 4; i++) begin
      lb_op(1'b1, 32'(i * 17), ok, rd);
      chk(32'(ok), 32'h1);
    end
    rdchk(A_CSR, 32'h340);
    chk(32'(vme_bus_req), 32'h1);
    fork
      lb_op(1'b0, 32'h0, ok, rd);
      begin
        repeat (12) @(posedge clk_sys);
        chk(32'(seen), 32'h0);
        stall <= 1'b0;
      end
    join
    chk(rd, RD_VAL);
    chk(hist, 32'h112233ee);
    rdchk(A_DATA, 32'h33);
    rdchk(A_ADDR, 32'h0010_0033);
    rdchk(A_CTL, 32'h08);
    // Queued bus error, stuck queue, clear discards head
    berr_on <= 1'b1;
    lb_op(1'b1, 32'h44, ok, rd);
    for (i = 0; i < 50 && local_interrupt_out !== 1'b1; i++)
      @(posedge clk_sys);
    chk(32'(local_interrupt_out), 32'h1);
    chk(32'(vme_bus_req), 32'h0);
    berr_on <= 1'b0;
    lb_op(1'b1, 32'h55, ok, rd);
    chk(32'(ok), 32'h1);
    repeat (20) @(posedge clk_sys);
    rdchk(A_CSR, 32'h242);
    chk(32'(seen), 32'h4);
    rdchk(A_DATA, 32'h44);
    wr(A_CSR, 32'h42);
    for (i = 0; i < 100 && seen !== 8'h5; i++) @(posedge clk_sys);
    chk(hist, 32'h2233ee55);
    chk(32'(local_interrupt_out), 32'h0);
    // Coupled writes, good and failing
    wr(A_CSR, 32'h41);
    lb_op(1'b1, 32'h77, ok, rd);
    chk(32'(seen), 32'h6);
    chk(32'(ok), 32'h1);
    berr_on <= 1'b1;
    lb_op(1'b1, 32'h66, ok, rd);
    chk(32'(ok), 32'h0);
    chk(32'(local_interrupt_out), 32'h1);
    rdchk(A_CSR, 32'h43);
    berr_on <= 1'b0;
    wr(A_CSR, 32'h42);
    // A64 entry carries the upper address register
    ent_ctl = 8'h0c;
    lb_op(1'b1, 32'h5a, ok, rd);
    ent_ctl = 8'h08;
    chk(vme_upper_addr, 32'hab12_cd34);
    chk(32'(vme_write), 32'h1);
    for (i = 0; i < 100 && seen !== 8'h7; i++) @(posedge clk_sys);
    chk(hist, 32'hee55_775a);
    // DMA fill option, release level, full-queue timeout
    stall <= 1'b1;
    dma_active <= 1'b1;
    wr(A_CSR, 32'h48);
    fill_n(14);
    chk(32'(vme_bus_req), 32'h0);
    chk(32'(flags), 32'h4);
    chk(32'(lb_release), 32'h0);
    fill_n(1);
    chk(32'(lb_release), 32'h1);
    chk(32'(flags), 32'h2);
    for (i = 0; i < 10 && vme_bus_req !== 1'b1; i++) @(posedge clk_sys);
    chk(32'(vme_bus_req), 32'h1);
    lb_op(1'b1, 32'h99, ok, rd);
    chk(32'(ok), 32'h0);
    rdchk(A_CSR, 32'hf48);
    wr(A_CSR, 32'h4c);
    rdchk(A_CSR, 32'h48);
    // MBLT entry outside A64/A32 is refused
    ent_ctl = 8'h84;
    lb_op(1'b1, 32'h5b, ok, rd);
    chk(32'(ok), 32'h0);
    ent_ctl = 8'h08;
    wr(A_CSR, 32'h50);
    fill_n(13);
    chk(32'(lb_release), 32'h0);
    chk(32'(flags), 32'h1);
    fill_n(1);
    chk(32'(lb_release), 32'h1);
    wr(A_CSR, 32'h44);
    rdchk(A_CSR, 32'h40);
    final_report;
  end

  // Whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    final_report;
  end
endmodule
`default_nettype wire
